// [osc_ctrl_pkg.sv]
// Package for the oscillator control bits block: register map, field
// positions, unlock keys, reset values and bus carriers.
// Assumes a 32-bit AHB-Lite register bus clocked by hclk.
package osc_ctrl_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_OSC_CONTROL = 8'h00;  // Oscillator control bits
   localparam logic [7:0] OFF_UNLOCK_KEY = 8'h04;   // Unlock key port
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;   // Sticky events, clear on read
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;     // Interrupt mask
   localparam logic [7:0] OFF_NEW_OSC = 8'h10;      // New oscillator selection
   localparam logic [7:0] OFF_CUR_OSC = 8'h14;      // Current oscillator, read only

   // Field positions in the control register
   localparam int unsigned BIT_SWITCH_REQ = 0;
   localparam int unsigned BIT_SOSC_EN = 1;
   localparam int unsigned BIT_USB_RC = 2;
   localparam int unsigned BIT_CLK_FAIL = 3;

   // Event bits in status and mask
   localparam int unsigned EV_CLK_FAIL = 0;
   localparam int unsigned EV_SWITCH_DONE = 1;
   localparam int unsigned EV_LOCK_VIOL = 2;
   localparam int unsigned EV_WIDTH = 3;

   localparam int unsigned OSC_SEL_W = 3;

   // Unlock keys, written in order to the key port
   localparam logic [31:0] UNLOCK_KEY1 = 32'haa996655;
   localparam logic [31:0] UNLOCK_KEY2 = 32'h556699aa;

   // Reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [OSC_SEL_W-1:0] OSC_SEL_RESET = 3'h0;
   localparam logic [EV_WIDTH-1:0] EV_RESET = 3'h0;

   // AHB transfer type codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // Request handshake toward the oscillator switcher
   typedef struct packed {
      logic req;
      logic [OSC_SEL_W-1:0] sel;
   } switch_req_t;

   // Latched AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ahb_phase_t;

endpackage

// [osc_unlock.sv]
// Unlock sequencer: two keys written in order open a one-write window.
// Assumes key writes and control writes arrive as one-cycle strobes on hclk.
`timescale 1ns/10ps
module osc_unlock
   import osc_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic key_wr,
   input wire logic [31:0] key_data,
   input wire logic ctrl_wr,
   output logic unlocked
);

   typedef enum logic [1:0] {LOCKED, KEY1_SEEN, OPEN} lock_state_t;

   lock_state_t state_q;  // Sequence position
   lock_state_t state_d;

   // Any wrong key drops back to locked; a control write consumes the window
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         LOCKED: begin
            if (key_wr && key_data == UNLOCK_KEY1) begin
               state_d = KEY1_SEEN;
            end
         end
         KEY1_SEEN: begin
            if (key_wr) begin
               state_d = (key_data == UNLOCK_KEY2) ? OPEN : LOCKED;
            end else if (ctrl_wr) begin
               state_d = LOCKED;
            end
         end
         OPEN: begin
            if (ctrl_wr || key_wr) begin
               state_d = LOCKED;
            end
         end
         default: state_d = LOCKED;
      endcase
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= LOCKED;
      end else begin
         state_q <= state_d;
      end
   end

   assign unlocked = (state_q == OPEN);

endmodule

// [osc_switcher.sv]
// Oscillator switch sequencer: takes a request, waits a settle time,
// then reports completion and the new current oscillator.
// Assumes requests come from the register block on the same clock.
`timescale 1ns/10ps
module osc_switcher
   import osc_ctrl_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = 16
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire switch_req_t sw_req,
   output logic busy,
   output logic done,
   output logic [OSC_SEL_W-1:0] cur_osc
);

   localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);

   logic [CW-1:0] cnt_q;  // Settle count, counts up to SETTLE_LAST
   logic busy_q;          // Switch in progress
   logic done_q;          // One-cycle completion pulse
   logic [OSC_SEL_W-1:0] cur_q;
   logic [OSC_SEL_W-1:0] tgt_q;

   wire start = sw_req.req && !busy_q && !done_q;
   wire finish = busy_q && (cnt_q == SETTLE_LAST);

   // Count the settle time; the clock mux changes only at the end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cur_q <= OSC_SEL_RESET;
         tgt_q <= OSC_SEL_RESET;
      end else begin
         done_q <= finish;
         if (start) begin
            busy_q <= 1'b1;
            cnt_q <= '0;
            tgt_q <= sw_req.sel;
         end else if (finish) begin
            busy_q <= 1'b0;
            cur_q <= tgt_q;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign cur_osc = cur_q;

endmodule

// [osc_ctrl.sv]
// Oscillator control bits with AHB-Lite register slave, unlock protection,
// clock-fail capture and a sticky interrupt.
// Assumes a single AHB-Lite master on hclk and fail detect from the monitor.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module osc_ctrl
   import osc_ctrl_pkg::*;
#(
   parameter bit HAS_USB = 1'b1,
   parameter int unsigned SETTLE_CYCLES = 16
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic clock_fail_in,
   output logic usb_rc_clock_select,
   output logic secondary_osc_enable,
   output logic [OSC_SEL_W-1:0] current_osc,
   output logic osc_irq
);

   ahb_phase_t ph_q;  // Address phase held for the data phase
   logic [31:0] rdata_q;  // Registered read data
   logic cf_meta_q;  // First synchroniser stage for the monitor input
   logic cf_sync_q;  // Second synchroniser stage
   logic cf_flag_q;  // Clock-fail status bit
   logic usb_rc_q;
   logic sosc_q;
   logic swreq_q;
   logic [OSC_SEL_W-1:0] nosc_q;
   logic [EV_WIDTH-1:0] ev_stat_q;
   logic [EV_WIDTH-1:0] ev_mask_q;
   logic unlocked;
   logic sw_done;
   logic [OSC_SEL_W-1:0] cur_osc;
   switch_req_t sw_req;

   // Address phase decode
   wire addr_take = hsel && hready && htrans == HTRANS_NONSEQ;
   wire wr_ctrl = ph_q.valid && ph_q.write && ph_q.addr == OFF_OSC_CONTROL;
   wire wr_key = ph_q.valid && ph_q.write && ph_q.addr == OFF_UNLOCK_KEY;
   wire wr_mask = ph_q.valid && ph_q.write && ph_q.addr == OFF_IRQ_MASK;
   wire wr_nosc = ph_q.valid && ph_q.write && ph_q.addr == OFF_NEW_OSC;
   wire rd_now = addr_take && !hwrite;
   wire [7:0] rd_addr = haddr[7:0];
   wire rd_stat = rd_now && rd_addr == OFF_IRQ_STATUS;

   // Protected write strobes
   wire ctrl_ok = wr_ctrl && unlocked;
   wire nosc_ok = wr_nosc && unlocked;
   wire lock_viol = (wr_ctrl || wr_nosc) && !unlocked;

   // Fail edge: hardware sets, nothing in software clears except reset
   wire cf_rise = cf_sync_q && !cf_flag_q;

   // Events for the sticky status
   wire [EV_WIDTH-1:0] ev_set = {lock_viol, sw_done, cf_rise};

   // Read data selection; unmapped addresses read zero
   wire [31:0] ctrl_word = {28'h0000000, cf_flag_q, usb_rc_q, sosc_q, swreq_q};
   wire [31:0] rd_mux =
      (rd_addr == OFF_OSC_CONTROL) ? ctrl_word :
      (rd_addr == OFF_IRQ_STATUS) ? {29'h0000000, ev_stat_q} :
      (rd_addr == OFF_IRQ_MASK) ? {29'h0000000, ev_mask_q} :
      (rd_addr == OFF_NEW_OSC) ? {29'h0000000, nosc_q} :
      (rd_addr == OFF_CUR_OSC) ? {29'h0000000, cur_osc} : 32'h00000000;

   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_q <= '0;
      end else if (hready) begin
         ph_q.valid <= addr_take;
         ph_q.write <= hwrite;
         ph_q.addr <= haddr[7:0];
      end
   end

   // Read data is sampled at address phase so the data phase has no wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else if (rd_now) begin
         rdata_q <= rd_mux;
      end
   end

   // Two-stage synchroniser on the asynchronous monitor output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cf_meta_q <= 1'b0;
         cf_sync_q <= 1'b0;
      end else begin
         cf_meta_q <= clock_fail_in;
         cf_sync_q <= cf_meta_q;
      end
   end

   // Clock-fail bit sticks once detected, cleared only by reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cf_flag_q <= 1'b0;
      end else if (cf_sync_q) begin
         cf_flag_q <= 1'b1;
      end
   end

   // Writable control bits behind the unlock window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         usb_rc_q <= CTRL_RESET[BIT_USB_RC];
         sosc_q <= CTRL_RESET[BIT_SOSC_EN];
      end else if (ctrl_ok) begin
         usb_rc_q <= HAS_USB ? hwdata[BIT_USB_RC] : 1'b0;
         sosc_q <= hwdata[BIT_SOSC_EN];
      end
   end

   // Switch request: software sets it, only completion clears it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         swreq_q <= CTRL_RESET[BIT_SWITCH_REQ];
      end else if (ctrl_ok && hwdata[BIT_SWITCH_REQ]) begin
         swreq_q <= 1'b1;
      end else if (sw_done) begin
         swreq_q <= 1'b0;
      end
   end

   // New oscillator selection, frozen while a switch runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nosc_q <= OSC_SEL_RESET;
      end else if (nosc_ok && !swreq_q) begin
         nosc_q <= hwdata[OSC_SEL_W-1:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_mask_q <= EV_RESET;
      end else if (wr_mask) begin
         ev_mask_q <= hwdata[EV_WIDTH-1:0];
      end
   end

   // Sticky status: a read clears it, but a same-cycle event still sets
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_stat_q <= EV_RESET;
      end else begin
         ev_stat_q <= (rd_stat ? EV_RESET : ev_stat_q) | ev_set;
      end
   end

   // Unlock sequencer
   osc_unlock u_unlock (
      .hclk(hclk),
      .hresetn(hresetn),
      .key_wr(wr_key),
      .key_data(hwdata),
      .ctrl_wr(wr_ctrl || wr_nosc),
      .unlocked(unlocked)
   );

   assign sw_req.req = swreq_q;
   assign sw_req.sel = nosc_q;

   // Switch sequencer
   osc_switcher #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_switcher (
      .hclk(hclk),
      .hresetn(hresetn),
      .sw_req(sw_req),
      .busy(),
      .done(sw_done),
      .cur_osc(cur_osc)
   );

   // Outputs
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign usb_rc_clock_select = usb_rc_q && HAS_USB;
   assign secondary_osc_enable = sosc_q;
   assign current_osc = cur_osc;
   assign osc_irq = |(ev_stat_q & ev_mask_q);

endmodule

// [osc_ctrl_monitor.sv]
// Checker for osc_ctrl: ties control bit readback and outputs to bus writes.
// Assumes it is bound to osc_ctrl with hready fed from hreadyout.
`timescale 1ns/10ps
module osc_ctrl_monitor
   import osc_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic clock_fail_in,
   input wire logic usb_rc_clock_select,
   input wire logic secondary_osc_enable,
   input wire logic [OSC_SEL_W-1:0] current_osc,
   input wire logic osc_irq
);
   // Control register address phase taken at this edge
   wire ctl_w = hsel & hready & (htrans == HTRANS_NONSEQ) & (haddr[7:0] == OFF_OSC_CONTROL);
   logic rd_q, wr_q, seen_q, ever_q; // Data phase flags and fail history
   logic [2:0] run_q; // Consecutive fail cycles, saturating
   logic [5:0] since_q; // Cycles since a control write; saturates so it never wraps
   // Track data phases and the fail input history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         seen_q <= 1'b0;
         ever_q <= 1'b0;
         run_q <= 3'h0;
         since_q <= 6'h3f;
      end else begin
         rd_q <= ctl_w & ~hwrite;
         wr_q <= ctl_w & hwrite;
         run_q <= clock_fail_in ? run_q + {2'h0, run_q != 3'h4} : 3'h0;
         seen_q <= seen_q | (run_q == 3'h4);
         ever_q <= ever_q | clock_fail_in;
         since_q <= wr_q ? 6'h0 : since_q + {5'h0, since_q != 6'h3f};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_fail; rd_q |-> (!seen_q || hrdata[3]) && (ever_q || !hrdata[3]); endproperty
   a_fail: assert property (p_fail) else $error("clock fail bit wrong");
   property p_usb; rd_q |-> hrdata[2] == usb_rc_clock_select; endproperty
   a_usb: assert property (p_usb) else $error("usb select differs");
   property p_sosc; rd_q |-> hrdata[1] == secondary_osc_enable; endproperty
   a_sosc: assert property (p_sosc) else $error("sosc enable differs");
   property p_chg; $changed({usb_rc_clock_select, secondary_osc_enable}) |-> $past(wr_q); endproperty
   a_chg: assert property (p_chg) else $error("enable moved without write");
   property p_req; rd_q && hrdata[0] |-> since_q < 6'd40; endproperty
   a_req: assert property (p_req) else $error("switch request stuck");
   property p_osc; $changed(current_osc) |-> since_q < 6'd40; endproperty
   a_osc: assert property (p_osc) else $error("oscillator moved unasked");
endmodule

// [test_osc_ctrl.sv]
// Self-checking bench for osc_ctrl driven through AHB-Lite register tasks.
// Assumes the package, design files and osc_ctrl_monitor are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %h got %h", nm, e, a); end end
module test_osc_ctrl
   import osc_ctrl_pkg::*;
;
   localparam int unsigned SETTLE = 8; // Short settle keeps the run brief
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clock_fail_in = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2; // Word transfers only
   logic hready, hreadyout, hresp, usb_rc_clock_select, secondary_osc_enable, osc_irq;
   logic [OSC_SEL_W-1:0] current_osc;
   logic usb_plain; // Select output of the variant without USB
   logic [31:0] hrdata_plain; // Read data of the variant without USB
   int miscompares = 0, checks_done = 0, n;
   assign hready = hreadyout; // Single slave drives the bus ready
   osc_ctrl #(.HAS_USB(1'b1), .SETTLE_CYCLES(SETTLE)) i_dut (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .clock_fail_in,
      .usb_rc_clock_select, .secondary_osc_enable, .current_osc, .osc_irq);
   // Variant without USB listens to the same bus; only its select and readback are watched
   osc_ctrl #(.HAS_USB(1'b0), .SETTLE_CYCLES(SETTLE)) i_dut_plain (.hclk, .hresetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(), .hresp(),
      .hrdata(hrdata_plain), .clock_fail_in, .usb_rc_clock_select(usb_plain),
      .secondary_osc_enable(), .current_osc(), .osc_irq());
   // 250 MHz clock
   initial begin
      forever #2 hclk = ~hclk;
   end
   // Verdict and stop
   task automatic end_sim;
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Wait for hready at a rising edge; a hang counts as a mismatch
   task automatic wait_rdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && k < 50) begin
         k++;
         @(posedge hclk);
      end
      if (k >= 50) begin
         miscompares++;
         end_sim();
      end
   endtask
   // One single word transfer; read data lands in q
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask
   // Two keys then the protected write
   task automatic unl_wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, OFF_UNLOCK_KEY, UNLOCK_KEY1);
      xfer(1'b1, OFF_UNLOCK_KEY, UNLOCK_KEY2);
      xfer(1'b1, a, d);
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(OFF_OSC_CONTROL);
      `CHK("ctrl reset", 32'h0, q)
      xfer(1'b1, OFF_OSC_CONTROL, 32'h6);
      rd(OFF_OSC_CONTROL);
      `CHK("ctrl locked", 32'h0, q)
      rd(OFF_IRQ_STATUS);
      `CHK("lock event", 32'h4, q)
      unl_wr(OFF_OSC_CONTROL, 32'h6);
      rd(OFF_OSC_CONTROL);
      `CHK("ctrl open", 32'h6, q)
      `CHK("usb on", 1'b1, usb_rc_clock_select)
      `CHK("sosc on", 1'b1, secondary_osc_enable)
      `CHK("usb absent", 1'b0, usb_plain)
      `CHK("plain ctrl", 32'h2, hrdata_plain)
      // The window closes after one write
      xfer(1'b1, OFF_OSC_CONTROL, 32'h0);
      rd(OFF_OSC_CONTROL);
      `CHK("relock", 32'h6, q)
      rd(OFF_IRQ_STATUS);
      `CHK("relock event", 32'h4, q)
      unl_wr(OFF_OSC_CONTROL, 32'h2);
      rd(OFF_OSC_CONTROL);
      `CHK("usb off", 1'b0, usb_rc_clock_select)
      `CHK("sosc kept", 1'b1, secondary_osc_enable)
      unl_wr(OFF_OSC_CONTROL, 32'h0);
      rd(OFF_OSC_CONTROL);
      `CHK("sosc off", 1'b0, secondary_osc_enable)
      // Switch to oscillator 5 with every event unmasked
      xfer(1'b1, OFF_IRQ_MASK, 32'h7);
      unl_wr(OFF_NEW_OSC, 32'h5);
      unl_wr(OFF_OSC_CONTROL, 32'h1);
      rd(OFF_OSC_CONTROL);
      `CHK("req held", 32'h1, q)
      `CHK("osc old", 3'h0, current_osc)
      n = 0;
      while (q[0] === 1'b1 && n < 40) begin
         rd(OFF_OSC_CONTROL);
         n++;
      end
      // A request that never clears is a hang: count it and stop
      if (n >= 40) begin
         miscompares++;
         end_sim();
      end
      `CHK("req cleared", 32'h0, q)
      `CHK("osc new", 3'h5, current_osc)
      rd(OFF_CUR_OSC);
      `CHK("cur reg", 32'h5, q)
      `CHK("irq on", 1'b1, osc_irq)
      rd(OFF_IRQ_STATUS);
      `CHK("done event", 32'h2, q)
      rd(OFF_IRQ_MASK);
      `CHK("mask", 32'h7, q)
      `CHK("irq off", 1'b0, osc_irq)
      // Clock failure while masked, then unmasked
      xfer(1'b1, OFF_IRQ_MASK, 32'h0);
      clock_fail_in <= 1'b1;
      repeat (4) @(posedge hclk);
      clock_fail_in <= 1'b0;
      rd(OFF_OSC_CONTROL);
      `CHK("fail bit", 32'h8, q)
      `CHK("irq masked", 1'b0, osc_irq)
      xfer(1'b1, OFF_IRQ_MASK, 32'h1);
      rd(8'h20);
      `CHK("unmapped", 32'h0, q)
      `CHK("irq unmasked", 1'b1, osc_irq)
      rd(OFF_IRQ_STATUS);
      `CHK("fail event", 32'h1, q)
      rd(OFF_OSC_CONTROL);
      `CHK("fail sticky", 32'h8, q)
      `CHK("irq cleared", 1'b0, osc_irq)
      end_sim();
   end
endmodule
bind osc_ctrl osc_ctrl_monitor i_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .clock_fail_in, .usb_rc_clock_select, .secondary_osc_enable,
   .current_osc, .osc_irq);
